/* hw/sfp_pkg.sv */
package sfp_pkg;
   // =====================================================
   // Timing
   // =====================================================
   localparam int unsigned CLK_PERIOD_NS            = 10;
   localparam int unsigned SUPPLY_TO_SELECT_DELAY_US = 85;
   localparam int unsigned POWERUP_WRITE_DELAY_MS    = 3;
   localparam int unsigned SEL_DELAY_CYC  = (SUPPLY_TO_SELECT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PUW_DELAY_CYC  = (POWERUP_WRITE_DELAY_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W          = 22;

   // =====================================================
   // Frame layout
   // =====================================================
   localparam int unsigned PAGE_ADDR_BITS = 13;
   localparam int unsigned BYTE_ADDR_BITS = 10;
   localparam int unsigned ADDR_BITS      = 24;
   localparam int unsigned OPC_BITS       = 8;
   localparam int unsigned BITCNT_W       = 7;
   localparam logic [7:0] OPC_MAIN_READ   = 8'hd2;
   localparam logic [7:0] OPC_BUF1_READ   = 8'hd4;
   localparam logic [7:0] OPC_BUF2_READ   = 8'hd6;
   localparam logic [7:0] OPC_BUF1_LREAD  = 8'hd1;
   localparam logic [7:0] OPC_BUF2_LREAD  = 8'hd3;
   localparam logic [7:0] OPC_STATUS      = 8'hd7;
   localparam logic [2:0] DUMMY_MAIN      = 3'h4;
   localparam logic [2:0] DUMMY_BUF       = 3'h1;
   localparam logic [2:0] DUMMY_NONE      = 3'h0;

   typedef enum logic [2:0] {
      SFP_ST_IDLE   = 3'b000,
      SFP_ST_OPC    = 3'b001,
      SFP_ST_ADDR   = 3'b010,
      SFP_ST_DUMMY  = 3'b011,
      SFP_ST_DATA   = 3'b100,
      SFP_ST_IGNORE = 3'b101
   } sfp_state_t;
endpackage

/* hw/sfp_pins_if.sv */
`timescale 1ns/100ps
interface sfp_pins_if;
   logic sclk_s;
   logic cs_fall;
   logic cs_high;
   logic sclk_rise;
   logic sclk_fall;
   logic sin_s;
   modport src (output sclk_s, cs_fall, cs_high, sclk_rise, sclk_fall, sin_s);
   modport dst (input sclk_s, cs_fall, cs_high, sclk_rise, sclk_fall, sin_s);
endinterface

/* hw/sfp_pin_sync.sv */
`timescale 1ns/100ps
module sfp_pin_sync
   import sfp_pkg::*;
(
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic sin,
   sfp_pins_if.src   pins
);
   // =====================================================
   // Two-stage synchronisers, then edge detect on stage two
   // =====================================================
   logic [2:0] meta_reg, meta_next;
   logic [2:0] sync_reg, sync_next;
   logic [2:0] last_reg, last_next;

   always_comb begin
      meta_next = {sclk, cs_n, sin};
      sync_next = meta_reg;
      last_next = sync_reg;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         // Idle bus: clock high, select high
         meta_reg <= 3'h6;
         sync_reg <= 3'h6;
         last_reg <= 3'h6;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         last_reg <= last_next;
      end
   end

   assign pins.sclk_s    = sync_reg[2];
   assign pins.cs_high   = sync_reg[1];
   assign pins.sin_s     = sync_reg[0];
   assign pins.cs_fall   = last_reg[1] & ~sync_reg[1];
   assign pins.sclk_rise = ~last_reg[2] & sync_reg[2];
   assign pins.sclk_fall = last_reg[2] & ~sync_reg[2];
endmodule

/* hw/sfp_frontend.sv */
`timescale 1ns/100ps
module sfp_frontend
   import sfp_pkg::*;
(
   input  wire logic                      mclk,
   input  wire logic                      reset_n,
   input  wire logic                      por_active,
   input  wire logic                      sclk,
   input  wire logic                      cs_n,
   input  wire logic                      sin,
   input  wire logic                      tx_bit,
   output logic                           sout,
   output logic                           sout_oe,
   output logic                           mode3,
   output logic                           standby,
   output logic                           select_ok,
   output logic                           pgm_allowed,
   output logic [7:0]                     opcode,
   output logic [PAGE_ADDR_BITS-1:0]      page_addr_bits,
   output logic [BYTE_ADDR_BITS-1:0]      byte_addr_bits,
   output logic                           cmd_valid,
   output logic                           data_bit,
   output logic                           data_bit_valid,
   output logic                           tx_shift
);
   sfp_pins_if pins ();

   sfp_pin_sync u_sync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .sclk    (sclk),
      .cs_n    (cs_n),
      .sin     (sin),
      .pins    (pins)
   );

   // =====================================================
   // Power-up timers
   // =====================================================
   logic [CNT_W-1:0] up_cnt_reg, up_cnt_next;
   logic             sel_ok_reg, sel_ok_next;
   logic             pgm_ok_reg, pgm_ok_next;
   logic             por_meta_reg, por_sync_reg;

   always_comb begin
      up_cnt_next = up_cnt_reg;
      sel_ok_next = sel_ok_reg;
      pgm_ok_next = pgm_ok_reg;
      if (por_sync_reg) begin
         up_cnt_next = '0;
         sel_ok_next = 1'b0;
         pgm_ok_next = 1'b0;
      end else begin
         if (!pgm_ok_reg) begin
            up_cnt_next = up_cnt_reg + CNT_W'(1);
         end
         if (up_cnt_reg >= CNT_W'(SEL_DELAY_CYC - 1)) begin
            sel_ok_next = 1'b1;
         end
         if (up_cnt_reg >= CNT_W'(PUW_DELAY_CYC - 1)) begin
            pgm_ok_next = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         por_meta_reg <= 1'b1;
         por_sync_reg <= 1'b1;
         up_cnt_reg   <= '0;
         sel_ok_reg   <= 1'b0;
         pgm_ok_reg   <= 1'b0;
      end else begin
         por_meta_reg <= por_active;
         por_sync_reg <= por_meta_reg;
         up_cnt_reg   <= up_cnt_next;
         sel_ok_reg   <= sel_ok_next;
         pgm_ok_reg   <= pgm_ok_next;
      end
   end

   // =====================================================
   // Command framing
   // =====================================================
   sfp_state_t               st_reg, st_next;
   logic                     mode3_reg, mode3_next;
   logic [BITCNT_W-1:0]      cnt_reg, cnt_next;
   logic [2:0]               dummy_reg, dummy_next;
   logic [7:0]               opc_reg, opc_next;
   logic [ADDR_BITS-1:0]     addr_reg, addr_next;
   logic                     cmdv_reg, cmdv_next;
   logic                     dbit_reg, dbit_next;
   logic                     dvld_reg, dvld_next;
   logic                     oe_reg, oe_next;
   logic                     so_reg, so_next;
   logic                     txs_reg, txs_next;
   logic [7:0]               opc_in;
   logic                     drive_phase;

   assign opc_in      = {opc_reg[6:0], pins.sin_s};
   // Status read drives right after its opcode, d1/d3 reads right after the address; other reads drive after dummies
   assign drive_phase = (st_reg == SFP_ST_DATA) && (opc_reg == OPC_STATUS || dummy_reg != DUMMY_NONE
                        || opc_reg == OPC_BUF1_LREAD || opc_reg == OPC_BUF2_LREAD);

   always_comb begin
      st_next    = st_reg;
      mode3_next = mode3_reg;
      cnt_next   = cnt_reg;
      dummy_next = dummy_reg;
      opc_next   = opc_reg;
      addr_next  = addr_reg;
      cmdv_next  = 1'b0;
      dbit_next  = dbit_reg;
      dvld_next  = 1'b0;
      oe_next    = oe_reg;
      so_next    = so_reg;
      txs_next   = 1'b0;
      if (por_sync_reg) begin
         st_next    = SFP_ST_IDLE;
         mode3_next = 1'b1;
         oe_next    = 1'b0;
      end else if (pins.cs_high) begin
         st_next = SFP_ST_IDLE;
         oe_next = 1'b0;
      end else if (pins.cs_fall) begin
         mode3_next = pins.sclk_s;
         cnt_next   = '0;
         st_next    = SFP_ST_OPC;
      end else begin
         unique case (st_reg)
            SFP_ST_OPC: begin
               if (pins.sclk_rise) begin
                  opc_next = opc_in;
                  cnt_next = cnt_reg + BITCNT_W'(1);
                  if (cnt_reg == BITCNT_W'(OPC_BITS - 1)) begin
                     cnt_next  = '0;
                     cmdv_next = (opc_in == OPC_STATUS);
                     if (opc_in == OPC_STATUS) begin
                        dummy_next = DUMMY_NONE;
                        st_next    = SFP_ST_DATA;
                     end else if (opc_in == OPC_MAIN_READ) begin
                        dummy_next = DUMMY_MAIN;
                        st_next    = SFP_ST_ADDR;
                     end else if (opc_in == OPC_BUF1_READ || opc_in == OPC_BUF2_READ) begin
                        dummy_next = DUMMY_BUF;
                        st_next    = SFP_ST_ADDR;
                     end else begin
                        dummy_next = DUMMY_NONE;
                        st_next    = SFP_ST_ADDR;
                     end
                  end
               end
            end
            SFP_ST_ADDR: begin
               if (pins.sclk_rise) begin
                  addr_next = {addr_reg[ADDR_BITS-2:0], pins.sin_s};
                  cnt_next  = cnt_reg + BITCNT_W'(1);
                  if (cnt_reg == BITCNT_W'(ADDR_BITS - 1)) begin
                     cnt_next = '0;
                     if (dummy_reg == DUMMY_NONE) begin
                        cmdv_next = 1'b1;
                        st_next   = SFP_ST_DATA;
                     end else begin
                        st_next = SFP_ST_DUMMY;
                     end
                  end
               end
            end
            SFP_ST_DUMMY: begin
               if (pins.sclk_rise) begin
                  cnt_next = cnt_reg + BITCNT_W'(1);
                  if (cnt_reg == BITCNT_W'({dummy_reg, 3'h0} - 7'h1)) begin
                     cnt_next  = '0;
                     cmdv_next = 1'b1;
                     st_next   = SFP_ST_DATA;
                  end
               end
            end
            SFP_ST_DATA: begin
               if (pins.sclk_rise) begin
                  dbit_next = pins.sin_s;
                  dvld_next = 1'b1;
               end
               if (pins.sclk_fall && drive_phase) begin
                  oe_next  = 1'b1;
                  so_next  = tx_bit;
                  txs_next = 1'b1;
               end
            end
            SFP_ST_IGNORE: begin
               // Early selection stays refused until select rises
               st_next = SFP_ST_IGNORE;
            end
            default: begin
               st_next = SFP_ST_IDLE;
            end
         endcase
      end
      // Selection too early after supply is not honoured
      if (!sel_ok_reg && !pins.cs_high && st_next == SFP_ST_OPC && pins.cs_fall) begin
         st_next = SFP_ST_IGNORE;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg    <= SFP_ST_IDLE;
         mode3_reg <= 1'b1;
         cnt_reg   <= '0;
         dummy_reg <= DUMMY_NONE;
         opc_reg   <= 8'h00;
         addr_reg  <= '0;
         cmdv_reg  <= 1'b0;
         dbit_reg  <= 1'b0;
         dvld_reg  <= 1'b0;
         oe_reg    <= 1'b0;
         so_reg    <= 1'b0;
         txs_reg   <= 1'b0;
      end else begin
         st_reg    <= st_next;
         mode3_reg <= mode3_next;
         cnt_reg   <= cnt_next;
         dummy_reg <= dummy_next;
         opc_reg   <= opc_next;
         addr_reg  <= addr_next;
         cmdv_reg  <= cmdv_next;
         dbit_reg  <= dbit_next;
         dvld_reg  <= dvld_next;
         oe_reg    <= oe_next;
         so_reg    <= so_next;
         txs_reg   <= txs_next;
      end
   end

   // =====================================================
   // Outputs
   // =====================================================
   logic standby_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         standby_reg <= 1'b0;
      end else begin
         standby_reg <= ~por_sync_reg & (st_next == SFP_ST_IDLE);
      end
   end

   assign sout           = so_reg;
   assign sout_oe        = oe_reg;
   assign mode3          = mode3_reg;
   assign standby        = standby_reg;
   assign select_ok      = sel_ok_reg;
   assign pgm_allowed    = pgm_ok_reg;
   assign opcode         = opc_reg;
   assign page_addr_bits = addr_reg[ADDR_BITS-2 -: PAGE_ADDR_BITS];
   assign byte_addr_bits = addr_reg[BYTE_ADDR_BITS-1:0];
   assign cmd_valid      = cmdv_reg;
   assign data_bit       = dbit_reg;
   assign data_bit_valid = dvld_reg;
   assign tx_shift       = txs_reg;
endmodule

/* bench/sfp_frontend_monitor.sv */
`timescale 1ns/100ps
module sfp_frontend_monitor
   import sfp_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic por_active,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sin,
   input wire logic tx_bit,
   input wire logic sout,
   input wire logic sout_oe,
   input wire logic mode3,
   input wire logic standby,
   input wire logic select_ok,
   input wire logic pgm_allowed,
   input wire logic cmd_valid,
   input wire logic data_bit,
   input wire logic data_bit_valid,
   input wire logic tx_shift
);
   // ==========
   // Supply timer
   // ==========
   // Saturates so the 3 ms bound never wraps
   logic [CNT_W-1:0] por_cnt_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         por_cnt_reg <= '0;
      end else if (por_active) begin
         por_cnt_reg <= '0;
      end else if (por_cnt_reg != '1) begin
         por_cnt_reg <= por_cnt_reg + CNT_W'(1);
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // ==========
   // Checks
   // ==========
   chk_por_quiet: assert property (por_active[*5] |-> !cmd_valid && !sout_oe && !standby)
      else $error("activity during supply reset");
   chk_por_mode: assert property (por_active[*5] |-> mode3)
      else $error("mode not 3 after supply reset");
   chk_mode_pick: assert property ($fell(cs_n) && select_ok && !por_active |-> ##6 mode3 == $past(sclk, 6))
      else $error("mode does not follow idle clock");
   chk_oe_idle: assert property (cs_n[*6] |-> !sout_oe)
      else $error("output driven while deselected");
   chk_cmd_sel: assert property (cmd_valid |-> !cs_n && !standby && select_ok)
      else $error("header without selection");
   chk_sel_early: assert property (por_cnt_reg < CNT_W'(SEL_DELAY_CYC) |-> !select_ok)
      else $error("select allowed too early");
   // Flag lags the pin by the two synchroniser stages only
   chk_sel_late: assert property (por_cnt_reg == CNT_W'(SEL_DELAY_CYC + 2) |-> select_ok)
      else $error("select not allowed in time");
   chk_pgm_early: assert property (por_cnt_reg < CNT_W'(PUW_DELAY_CYC) |-> !pgm_allowed)
      else $error("program allowed too early");
   chk_tx_fall: assert property (tx_shift |-> !sclk && !$past(sclk) && sout_oe && sout == $past(tx_bit))
      else $error("output not shifted on falling clock");
   chk_rx_rise: assert property (data_bit_valid |-> sclk && $past(sclk) && data_bit == sin)
      else $error("input not captured on rising clock");
   cover property (cmd_valid && !mode3);
   cover property (cmd_valid && mode3);
   cover property (tx_shift);
   cover property ($rose(select_ok));
endmodule
bind sfp_frontend sfp_frontend_monitor u_mon (.mclk, .reset_n, .por_active, .sclk, .cs_n, .sin, .tx_bit, .sout,
   .sout_oe, .mode3, .standby, .select_ok, .pgm_allowed, .cmd_valid, .data_bit, .data_bit_valid, .tx_shift);

/* bench/sfp_host_model.sv */
`timescale 1ns/100ps
module sfp_host_model (
   input  wire logic mclk,
   input  wire logic sout,
   input  wire logic sout_oe,
   output logic      sclk,
   output logic      cs_n,
   output logic      sin
);
   logic [7:0] rx_reg;
   int         half = 10;
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      sin = 1'b0;
      rx_reg = 8'h00;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // Clock parked at its idle level before the select edge
   task automatic select(input logic idle);
      sclk = idle;
      wait_cyc(half);
      cs_n = 1'b0;
      wait_cyc(half);
   endtask
   task automatic xfer(input logic [63:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         sclk = 1'b0;
         sin = v[i];
         wait_cyc(half);
         sclk = 1'b1;
         // Undriven line reads as the inverse so a stale bit never matches
         rx_reg = {rx_reg[6:0], sout_oe ? sout : ~sout};
         wait_cyc(half);
      end
   endtask
   // Released data line shows the inverse so stale values never match
   task automatic deselect();
      cs_n = 1'b1;
      sin = ~sin;
      wait_cyc(half);
   endtask
endmodule

/* bench/serial_flash_powerup_frontend_tb_top.sv */
`timescale 1ns/100ps
module serial_flash_powerup_frontend_tb_top;
   logic        mclk, reset_n, por_active, tx_bit, sclk, cs_n, sin, sout, sout_oe, mode3, standby;
   logic        select_ok, pgm_allowed, cmd_valid, data_bit, data_bit_valid, tx_shift;
   logic [7:0]  opcode, db;
   logic [7:0]  txp = 8'ha5;
   logic [12:0] page_addr_bits;
   logic [9:0]  byte_addr_bits;
   logic [7:0]  opcs [6] = '{8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd6, 8'hd7};
   int          nds [6] = '{0, 4, 0, 1, 1, 0};
   int          bad_count = 0, check_count = 0, cv_cnt = 0, tx_cnt = 0, cyc = 0;
   assign tx_bit = txp[7];
   sfp_frontend u_dut (.mclk, .reset_n, .por_active, .sclk, .cs_n, .sin, .tx_bit, .sout, .sout_oe, .mode3,
      .standby, .select_ok, .pgm_allowed, .opcode, .page_addr_bits, .byte_addr_bits, .cmd_valid, .data_bit,
      .data_bit_valid, .tx_shift);
   sfp_host_model u_host (.mclk, .sout, .sout_oe, .sclk, .cs_n, .sin);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // ==========
   // Monitors and timeout
   // ==========
   always @(posedge mclk) begin
      cyc++;
      if (cmd_valid) cv_cnt++;
      if (tx_shift) tx_cnt++;
      if (data_bit_valid) db = {db[6:0], data_bit};
      if (cyc > 60000) begin
         bad_count++;
         final_report();
      end
   end
   always @(negedge mclk) if (tx_shift) txp <= {txp[6:0], txp[7]};
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ==========
   // Scenarios
   // ==========
   task automatic frame_d7();
      cv_cnt = 0;
      tx_cnt = 0;
      u_host.select(1'b1);
      u_host.xfer(64'hd700, 16);
      u_host.deselect();
   endtask
   task automatic t_por();
      frame_d7();
      check(cv_cnt, 0, "por header");
      check(standby, 0, "por standby");
      check(mode3, 1, "por mode");
      check(sout_oe, 0, "por oe");
      $display("test por done");
   endtask
   task automatic t_presel();
      por_active = 1'b0;
      repeat (10) @(negedge mclk);
      check(standby, 1, "standby");
      frame_d7();
      check(cv_cnt + tx_cnt, 0, "early select");
      // Host holds off selection until the supply delay is over
      repeat (9000) begin
         if (select_ok) break;
         @(negedge mclk);
      end
      check(select_ok, 1, "select window");
      check(pgm_allowed, 0, "program window");
      u_host.select(1'b1);
      // Opcode and ten address bits, then select rises mid-header
      u_host.xfer(64'h34800, 18);
      u_host.deselect();
      check(opcode, 8'hd2, "aborted opcode");
      check(cv_cnt, 0, "aborted header");
      $display("test presel done");
   endtask
   task automatic t_cmd(input logic [7:0] opc, input int nd, input logic idle, input logic [12:0] pg,
                        input logic [9:0] by);
      logic [63:0] v;
      int          hb;
      hb = 8 + (opc != 8'hd7 ? 24 : 0) + nd * 8;
      v = {opc, 1'b1, pg, by, 32'h5a5a5a5a} >> (64 - hb);
      cv_cnt = 0;
      tx_cnt = 0;
      u_host.select(idle);
      check(mode3, idle, "mode");
      u_host.xfer(v >> 1, hb - 1);
      check(cv_cnt, 0, "header short");
      u_host.xfer(v, 1);
      check(cv_cnt, 1, "header end");
      check(opcode, opc, "opcode");
      if (opc != 8'hd7) check(byte_addr_bits, by, "byte addr");
      if (opc == 8'hd2) check(page_addr_bits, pg, "page addr");
      u_host.xfer(64'h3c, 8);
      check(db, 8'h3c, "data in");
      check(u_host.rx_reg, 8'ha5, "data out");
      check(tx_cnt, 8, "shift count");
      u_host.deselect();
      check(sout_oe, 0, "oe released");
      check(standby, 1, "back to standby");
      $display("test cmd %h mode %0d done", opc, idle);
   endtask
   task automatic t_rst();
      check(mode3, 0, "mode before reset");
      reset_n = 1'b0;
      repeat (2) @(negedge mclk);
      reset_n = 1'b1;
      check(mode3, 1, "reset mode");
      check(sout_oe, 0, "reset oe");
      check(select_ok, 0, "reset select window");
      repeat (10) @(negedge mclk);
      check(standby, 1, "reset standby");
      check(mode3, 1, "mode after reset");
      $display("test reset done");
   endtask
   initial begin
      reset_n = 1'b0;
      por_active = 1'b1;
      db = 8'h00;
      repeat (16) @(negedge mclk);
      reset_n = 1'b1;
      repeat (4) @(negedge mclk);
      t_por();
      t_presel();
      for (int m = 0; m < 2; m++)
         for (int i = 0; i < 6; i++)
            t_cmd(opcs[i], nds[i], m[0], m[0] ? 13'h1fff : 13'h0001, m[0] ? 10'h000 : 10'h3ff);
      // Leave mode 0 behind so the mid-run reset has something to undo
      t_cmd(8'hd7, 0, 1'b0, 13'h0001, 10'h3ff);
      t_rst();
      final_report();
   end
endmodule
